// File: lcd_cmd_pkg.sv
`default_nettype none
package lcd_cmd_pkg;
   // Register offsets
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_DATA = 8'h04;
   localparam logic [7:0] ADDR_RSP = 8'h08;
   localparam logic [7:0] ADDR_STAT = 8'h0c;
   localparam logic [7:0] ADDR_TMASK = 8'h10;
   localparam logic [7:0] ADDR_RBYTE = 8'h20;
   localparam int RSP_BYTES = 9;
   localparam int RSP_LEN_LSB = 8;
   localparam int RSP_VALID_BIT = 16;
   localparam int STAT_FANEN_LSB = 8;
   // Command codes, reply flags and report types
   localparam logic [7:0] CMD_LINE2 = 8'h08;
   localparam logic [7:0] CMD_GLYPH = 8'h09;
   localparam logic [7:0] CMD_PEEK = 8'h0a;
   localparam logic [7:0] CMD_CURPOS = 8'h0b;
   localparam logic [7:0] CMD_CURSTYLE = 8'h0c;
   localparam logic [7:0] CMD_CONTRAST = 8'h0d;
   localparam logic [7:0] CMD_BACKLIGHT = 8'h0e;
   localparam logic [7:0] CMD_FANRPT = 8'h10;
   localparam logic [7:0] CMD_FANPWR = 8'h11;
   localparam logic [7:0] CMD_SENSINFO = 8'h12;
   localparam logic [7:0] CMD_TEMPRPT = 8'h13;
   localparam logic [7:0] ACK_FLAG = 8'h40;
   localparam logic [7:0] NAK_FLAG = 8'hc0;
   localparam logic [7:0] RPT_FAN = 8'h81;
   localparam logic [7:0] RPT_TEMP = 8'h82;
   // Lengths and ranges
   localparam logic [4:0] LEN_ONE = 5'h01;
   localparam logic [4:0] LEN_TWO = 5'h02;
   localparam logic [4:0] LEN_FOUR = 5'h04;
   localparam logic [4:0] LEN_GLYPH = 5'h09;
   localparam logic [4:0] LEN_LINE = 5'h10;
   localparam logic [4:0] LEN_OVER = 5'h11;
   localparam logic [3:0] LEN_REPLY = 4'h9;
   localparam logic [7:0] GLYPH_MAX = 8'h3f;
   localparam logic [7:0] GLYPH_IDX_MAX = 8'h07;
   localparam logic [7:0] FAN_MAX = 8'h64;
   localparam logic [6:0] FAN_FULL = 7'h64;
   localparam logic [7:0] COL_MAX = 8'h0f;
   localparam logic [7:0] ROW_MAX = 8'h01;
   localparam logic [7:0] STYLE_MAX = 8'h03;
   localparam logic [7:0] FANMASK_MAX = 8'h0f;
   localparam logic [7:0] SENS_MAX = 8'h1f;
   localparam logic [7:0] PEEK_GLYPH_BASE = 8'h40;
   localparam logic [7:0] PEEK_CHAR_BASE = 8'h80;
   localparam logic [7:0] PEEK_CHAR_END = 8'h9f;
   localparam logic [4:0] LINE2_BASE = 5'h10;
   // Values after reset
   localparam logic [7:0] CHAR_RST = 8'h20;
   localparam logic [7:0] CONTRAST_RST = 8'h7f;
   localparam logic [7:0] BACKLIGHT_RST = 8'h64;
   localparam logic [6:0] FAN_RST = 7'h00;
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int EIGHTH_NS = 125000000;
   localparam int EIGHTH_CYCLES = EIGHTH_NS / CLK_PERIOD_NS;
   localparam logic [2:0] LAST_SLOT = 3'h7;
endpackage
`default_nettype wire

// File: tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tick_if;
   logic tick;
   logic [2:0] slot;
   modport src (output tick, output slot);
   modport dst (input tick, input slot);
endinterface
`default_nettype wire

// File: eighth_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Eighth-second enable and slot within the one-second frame
module eighth_timer #(
   parameter int CYCLES = lcd_cmd_pkg::EIGHTH_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   tick_if.src t
);
   logic [31:0] count;
   logic [31:0] next_count;
   logic next_tick;
   logic [2:0] next_slot;

   always_comb begin
      next_tick = 1'b0;
      next_slot = t.slot;
      next_count = count + 32'h1;
      if (count == 32'(CYCLES - 1)) begin
         next_count = 32'h0;
         next_tick = 1'b1;
      end
      if (t.tick) begin
         next_slot = t.slot + 3'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count <= 32'h0;
         t.tick <= 1'b0;
         t.slot <= 3'h0;
      end else begin
         count <= next_count;
         t.tick <= next_tick;
         t.slot <= next_slot;
      end
   end
endmodule
`default_nettype wire

// File: lcd_cmd_handler.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lcd_cmd_handler #(
   parameter int EIGHTH_CYCLES = lcd_cmd_pkg::EIGHTH_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic idWrEn,
   input wire logic [4:0] idWrIdx,
   input wire logic [63:0] idWrData,
   output logic [3:0] cursorCol,
   output logic cursorRow,
   output logic [1:0] cursorStyle,
   output logic [7:0] contrast,
   output logic [7:0] backlight,
   output logic [3:0][6:0] fanDrive,
   output logic rptValid,
   output logic [7:0] rptType,
   output logic [4:0] rptIndex
);
   tick_if tk ();
   eighth_timer #(.CYCLES(EIGHTH_CYCLES)) u_timer (
      .clk(clk),
      .rst_b(rst_b),
      .t(tk)
   );

   logic [7:0] dbuf [16];
   logic [4:0] dcnt;
   logic [7:0] chars [32];
   logic [5:0] glyph [64];
   logic [6:0] fanLevel [4];
   logic [3:0] fanEn;
   logic [31:0] tempMask;
   logic [31:0] pend;
   logic [63:0] sensId [32];
   logic [31:0] sensOk;
   logic [7:0] rsp [9];
   logic [7:0] rspType;
   logic [3:0] rspLen;
   logic rspValid;

   logic [7:0] next_dbuf [16];
   logic [4:0] next_dcnt;
   logic [7:0] next_chars [32];
   logic [5:0] next_glyph [64];
   logic [6:0] next_fanLevel [4];
   logic [3:0] next_fanEn;
   logic [31:0] next_tempMask;
   logic [31:0] next_pend;
   logic [63:0] next_sensId [32];
   logic [31:0] next_sensOk;
   logic [7:0] next_rsp [9];
   logic [7:0] next_rspType;
   logic [3:0] next_rspLen;
   logic next_rspValid;
   logic [3:0] next_cursorCol;
   logic next_cursorRow;
   logic [1:0] next_cursorStyle;
   logic [7:0] next_contrast;
   logic [7:0] next_backlight;
   logic [3:0][6:0] next_fanDrive;
   logic next_rptValid;
   logic [7:0] next_rptType;
   logic [4:0] next_rptIndex;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;

   logic wr;
   logic ok;
   logic bad;
   logic [7:0] cmd;
   logic [3:0] rlen;
   logic [7:0] d0;
   logic [5:0] ga;
   logic [4:0] ca;
   logic [4:0] pick;
   logic [7:0] ridx;

   always_comb begin
      next_dbuf = dbuf;
      next_dcnt = dcnt;
      next_chars = chars;
      next_glyph = glyph;
      next_fanLevel = fanLevel;
      next_fanEn = fanEn;
      next_tempMask = tempMask;
      next_pend = pend;
      next_sensId = sensId;
      next_sensOk = sensOk;
      next_rsp = rsp;
      next_rspType = rspType;
      next_rspLen = rspLen;
      next_rspValid = rspValid;
      next_cursorCol = cursorCol;
      next_cursorRow = cursorRow;
      next_cursorStyle = cursorStyle;
      next_contrast = contrast;
      next_backlight = backlight;
      next_rptValid = 1'b0;
      next_rptType = rptType;
      next_rptIndex = rptIndex;
      next_prdata = prdata;
      next_pslverr = pslverr;
      next_pready = psel & penable & ~pready;
      wr = psel & penable & pready & pwrite;
      ok = 1'b0;
      bad = 1'b0;
      cmd = pwdata[7:0];
      rlen = 4'h0;
      d0 = dbuf[0];
      ga = 6'h0;
      ca = 5'h0;
      pick = 5'h0;
      ridx = (paddr - lcd_cmd_pkg::ADDR_RBYTE) >> 2;
      // Bus read data and decode, one cycle before pready
      if (psel & penable & ~pready) begin
         next_prdata = 32'h0;
         next_pslverr = 1'b0;
         case (paddr)
            lcd_cmd_pkg::ADDR_CMD, lcd_cmd_pkg::ADDR_DATA: begin
               next_prdata = 32'h0;
            end
            lcd_cmd_pkg::ADDR_RSP: begin
               next_prdata[7:0] = rspType;
               next_prdata[lcd_cmd_pkg::RSP_LEN_LSB +: 4] = rspLen;
               next_prdata[lcd_cmd_pkg::RSP_VALID_BIT] = rspValid;
            end
            lcd_cmd_pkg::ADDR_STAT: begin
               next_prdata[4:0] = dcnt;
               next_prdata[lcd_cmd_pkg::STAT_FANEN_LSB +: 4] = fanEn;
            end
            lcd_cmd_pkg::ADDR_TMASK: begin
               next_prdata = tempMask;
            end
            default: begin
               if (paddr >= lcd_cmd_pkg::ADDR_RBYTE && paddr[1:0] == 2'h0
                   && ridx < 8'(lcd_cmd_pkg::RSP_BYTES)) begin
                  next_prdata[7:0] = rsp[ridx[3:0]];
               end else begin
                  next_pslverr = 1'b1;
               end
            end
         endcase
      end
      if (wr && paddr == lcd_cmd_pkg::ADDR_DATA) begin
         if (dcnt < lcd_cmd_pkg::LEN_LINE) begin
            next_dbuf[dcnt[3:0]] = pwdata[7:0];
         end
         if (dcnt < lcd_cmd_pkg::LEN_OVER) begin
            next_dcnt = dcnt + 5'h1;
         end
      end
      if (wr && paddr == lcd_cmd_pkg::ADDR_RSP) begin
         next_rspValid = 1'b0;
      end
      // Command execution
      if (wr && paddr == lcd_cmd_pkg::ADDR_CMD) begin
         case (cmd)
            lcd_cmd_pkg::CMD_LINE2: begin
               ok = (dcnt == lcd_cmd_pkg::LEN_LINE);
               for (int i = 0; i < 16; i++) begin
                  if (ok) begin
                     next_chars[lcd_cmd_pkg::LINE2_BASE + 5'(i)] = dbuf[i];
                  end
               end
            end
            lcd_cmd_pkg::CMD_GLYPH: begin
               for (int i = 1; i < 9; i++) begin
                  bad = bad | (dbuf[i] > lcd_cmd_pkg::GLYPH_MAX);
               end
               ok = (dcnt == lcd_cmd_pkg::LEN_GLYPH) && !bad
                  && (d0 <= lcd_cmd_pkg::GLYPH_IDX_MAX);
               for (int r = 0; r < 8; r++) begin
                  if (ok) begin
                     // Row 0 is the top; bit 5 is the leftmost pixel
                     next_glyph[{d0[2:0], 3'(r)}] = dbuf[r + 1][5:0];
                  end
               end
            end
            lcd_cmd_pkg::CMD_PEEK: begin
               ok = (dcnt == lcd_cmd_pkg::LEN_ONE) && (d0 >= lcd_cmd_pkg::PEEK_GLYPH_BASE)
                  && (d0 <= lcd_cmd_pkg::PEEK_CHAR_END);
               rlen = lcd_cmd_pkg::LEN_REPLY;
               if (ok) begin
                  next_rsp[0] = d0;
               end
               for (int i = 0; i < 8; i++) begin
                  ga = d0[5:0] + 6'(i);
                  ca = d0[4:0] + 5'(i);
                  if (ok && d0 >= lcd_cmd_pkg::PEEK_CHAR_BASE) begin
                     next_rsp[i + 1] = chars[ca];
                  end else if (ok) begin
                     next_rsp[i + 1] = {2'h0, glyph[ga]};
                  end
               end
            end
            lcd_cmd_pkg::CMD_CURPOS: begin
               ok = (dcnt == lcd_cmd_pkg::LEN_TWO) && (d0 <= lcd_cmd_pkg::COL_MAX)
                  && (dbuf[1] <= lcd_cmd_pkg::ROW_MAX);
               if (ok) begin
                  next_cursorCol = d0[3:0];
                  next_cursorRow = dbuf[1][0];
               end
            end
            lcd_cmd_pkg::CMD_CURSTYLE: begin
               ok = (dcnt == lcd_cmd_pkg::LEN_ONE) && (d0 <= lcd_cmd_pkg::STYLE_MAX);
               if (ok) begin
                  next_cursorStyle = d0[1:0];
               end
            end
            lcd_cmd_pkg::CMD_CONTRAST: begin
               ok = (dcnt == lcd_cmd_pkg::LEN_ONE);
               if (ok) begin
                  next_contrast = d0;
               end
            end
            lcd_cmd_pkg::CMD_BACKLIGHT: begin
               ok = (dcnt == lcd_cmd_pkg::LEN_ONE);
               if (ok) begin
                  next_backlight = d0;
               end
            end
            lcd_cmd_pkg::CMD_FANRPT: begin
               ok = (dcnt == lcd_cmd_pkg::LEN_ONE) && (d0 <= lcd_cmd_pkg::FANMASK_MAX);
               if (ok) begin
                  next_fanEn = d0[3:0];
               end
            end
            lcd_cmd_pkg::CMD_FANPWR: begin
               for (int i = 0; i < 4; i++) begin
                  bad = bad | (dbuf[i] > lcd_cmd_pkg::FAN_MAX);
               end
               ok = (dcnt == lcd_cmd_pkg::LEN_FOUR) && !bad;
               for (int i = 0; i < 4; i++) begin
                  if (ok) begin
                     next_fanLevel[i] = dbuf[i][6:0];
                  end
               end
            end
            lcd_cmd_pkg::CMD_SENSINFO: begin
               ok = (dcnt == lcd_cmd_pkg::LEN_ONE) && (d0 <= lcd_cmd_pkg::SENS_MAX);
               rlen = lcd_cmd_pkg::LEN_REPLY;
               if (ok) begin
                  next_rsp[0] = d0;
               end
               for (int i = 0; i < 8; i++) begin
                  if (ok) begin
                     // Byte 0 of the identifier is the family code
                     next_rsp[i + 1] = sensId[d0[4:0]][8 * i +: 8];
                  end
               end
            end
            lcd_cmd_pkg::CMD_TEMPRPT: begin
               ok = (dcnt == lcd_cmd_pkg::LEN_FOUR);
               if (ok) begin
                  next_tempMask = {dbuf[3], dbuf[2], dbuf[1], dbuf[0]};
               end
            end
            default: begin
               ok = 1'b0;
            end
         endcase
         next_rspType = cmd | (ok ? lcd_cmd_pkg::ACK_FLAG : lcd_cmd_pkg::NAK_FLAG);
         next_rspLen = ok ? rlen : 4'h0;
         next_rspValid = 1'b1;
         next_dcnt = 5'h0;
      end
      // Identifiers captured by the sensor bus scan at power-up
      if (idWrEn) begin
         next_sensId[idWrIdx] = idWrData;
         next_sensOk[idWrIdx] = 1'b1;
      end
      // Periodic reports: fan in its slot, temperatures drained after
      for (int i = 31; i >= 0; i--) begin
         if (pend[i]) begin
            pick = 5'(i);
         end
      end
      if (tk.tick && fanEn[tk.slot[1:0]]) begin
         next_rptValid = 1'b1;
         next_rptType = lcd_cmd_pkg::RPT_FAN;
         next_rptIndex = {3'h0, tk.slot[1:0]};
      end else if (pend != 32'h0) begin
         next_rptValid = 1'b1;
         next_rptType = lcd_cmd_pkg::RPT_TEMP;
         next_rptIndex = pick;
         next_pend[pick] = 1'b0;
      end
      if (tk.tick && tk.slot == lcd_cmd_pkg::LAST_SLOT) begin
         next_pend = next_pend | (tempMask & sensOk);
      end
      for (int i = 0; i < 4; i++) begin
         next_fanDrive[i] = (fanEn[i] && tk.slot[1:0] == 2'(i))
            ? lcd_cmd_pkg::FAN_FULL : fanLevel[i];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < 16; i++) begin
            dbuf[i] <= 8'h00;
         end
         for (int i = 0; i < 32; i++) begin
            chars[i] <= lcd_cmd_pkg::CHAR_RST;
            sensId[i] <= 64'h0;
         end
         for (int i = 0; i < 64; i++) begin
            glyph[i] <= 6'h00;
         end
         for (int i = 0; i < 4; i++) begin
            fanLevel[i] <= lcd_cmd_pkg::FAN_RST;
         end
         for (int i = 0; i < 9; i++) begin
            rsp[i] <= 8'h00;
         end
         dcnt <= 5'h0;
         fanEn <= 4'h0;
         tempMask <= 32'h0;
         pend <= 32'h0;
         sensOk <= 32'h0;
         rspType <= 8'h00;
         rspLen <= 4'h0;
         rspValid <= 1'b0;
         cursorCol <= 4'h0;
         cursorRow <= 1'b0;
         cursorStyle <= 2'h0;
         contrast <= lcd_cmd_pkg::CONTRAST_RST;
         backlight <= lcd_cmd_pkg::BACKLIGHT_RST;
         fanDrive <= '0;
         rptValid <= 1'b0;
         rptType <= 8'h00;
         rptIndex <= 5'h00;
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         dbuf <= next_dbuf;
         chars <= next_chars;
         sensId <= next_sensId;
         glyph <= next_glyph;
         fanLevel <= next_fanLevel;
         rsp <= next_rsp;
         dcnt <= next_dcnt;
         fanEn <= next_fanEn;
         tempMask <= next_tempMask;
         pend <= next_pend;
         sensOk <= next_sensOk;
         rspType <= next_rspType;
         rspLen <= next_rspLen;
         rspValid <= next_rspValid;
         // Settable state held at the ports for the boot store
         cursorCol <= next_cursorCol;
         cursorRow <= next_cursorRow;
         cursorStyle <= next_cursorStyle;
         contrast <= next_contrast;
         backlight <= next_backlight;
         fanDrive <= next_fanDrive;
         rptValid <= next_rptValid;
         rptType <= next_rptType;
         rptIndex <= next_rptIndex;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   logic cmdWr;
   assign cmdWr = wr && paddr == lcd_cmd_pkg::ADDR_CMD;

   a_reply_type: assert property (
      cmdWr |=> rspValid && rspType[5:0] == $past(pwdata[5:0]) && rspType[6])
      else $error("reply type not command with 0x40");
   a_line2_write: assert property (
      cmdWr && cmd == lcd_cmd_pkg::CMD_LINE2 && dcnt == lcd_cmd_pkg::LEN_LINE
      |=> chars[16] == $past(dbuf[0]) && chars[31] == $past(dbuf[15]))
      else $error("bottom line not written");
   a_glyph_rows: assert property (
      cmdWr && cmd == lcd_cmd_pkg::CMD_GLYPH && ok
      |=> glyph[{$past(d0[2:0]), 3'h0}] == $past(dbuf[1][5:0])
      && glyph[{$past(d0[2:0]), 3'h7}] == $past(dbuf[8][5:0]))
      else $error("glyph rows misplaced");
   a_bad_len_nak: assert property (
      cmdWr && cmd == lcd_cmd_pkg::CMD_CURPOS && !ok
      |=> rspType == 8'hcb && $stable(cursorCol) && rspLen == 4'h0)
      else $error("bad packet executed");
   a_cursor_move: assert property (
      cmdWr && cmd == lcd_cmd_pkg::CMD_CURPOS && ok
      |=> cursorCol == $past(d0[3:0]) ##1 cursorCol == $past(d0[3:0], 2))
      else $error("cursor not moved");
   a_fan_force: assert property (
      fanEn[tk.slot[1:0]] |=> fanDrive[$past(tk.slot[1:0])] == lcd_cmd_pkg::FAN_FULL)
      else $error("reported fan not at full power");
   a_fan_report: assert property (
      tk.tick && fanEn[tk.slot[1:0]] |=> rptValid && rptType == 8'h81
      && rptIndex == {3'h0, $past(tk.slot[1:0])})
      else $error("fan report missing");
   a_sensor_reply: assert property (
      cmdWr && cmd == lcd_cmd_pkg::CMD_SENSINFO && ok
      |=> rspLen == 4'h9 && rsp[0] == $past(d0) && rsp[1] == $past(sensId[d0[4:0]][7:0]))
      else $error("sensor reply wrong");
   a_temp_mask: assert property (
      cmdWr && cmd == lcd_cmd_pkg::CMD_TEMPRPT && ok
      |=> tempMask[8] == $past(dbuf[1][0]) && tempMask[31] == $past(dbuf[3][7]))
      else $error("temperature mask misordered");
endmodule
`default_nettype wire

// File: sensor_scan_model.sv
`timescale 1ns/1ps
`default_nettype none
// Sensor bus scan at power-up: one identifier per pulse
module sensor_scan_model #(
   parameter logic [7:0] FAMILY = 8'h3c, // Arbitrary family code
   parameter int COUNT = 4,
   parameter logic [2:0] PIN_DRIVE_MODE_FIELD = 3'h7,
   parameter logic PIN_USER_FLAG = 1'b0
) (
   input wire logic clk,
   input wire logic rst_b,
   output logic idWrEn,
   output logic [4:0] idWrIdx,
   output logic [63:0] idWrData
);
   logic [5:0] step;
   logic [5:0] next_step;
   logic [63:0] ident;
   always_comb begin
      next_step = (step < 6'(2 * COUNT)) ? step + 6'h01 : step;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         step <= 6'h00;
      end else begin
         step <= next_step;
      end
   end
   // Family code leads the identifier
   assign ident = {{7{3'h0, step[5:1]}}, FAMILY};
   // Enumeration pulses after reset; idle lines show inverted values
   // Bus only scans with its pin in sensor mode, not user pin
   assign idWrEn = (PIN_DRIVE_MODE_FIELD == 3'h7) && !PIN_USER_FLAG
      && step[0] && (step < 6'(2 * COUNT));
   assign idWrIdx = idWrEn ? step[5:1] : ~step[5:1];
   assign idWrData = idWrEn ? ident : ~ident;
endmodule
`default_nettype wire

// File: lcd_fan_sensor_command_handler_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module lcd_fan_sensor_command_handler_tb;
   localparam logic [7:0] FAM = 8'h3c; // Arbitrary family code
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, idWrEn, cursorRow, rptValid;
   logic [4:0] idWrIdx, rptIndex;
   logic [63:0] idWrData;
   logic [3:0] cursorCol;
   logic [1:0] cursorStyle;
   logic [7:0] contrast, backlight, rptType;
   logic [3:0][6:0] fanDrive;
   logic [31:0] r = 32'h1e5c1a47;
   logic [7:0] dq[$];
   logic [7:0] eq[$];
   logic [6:0] fl[4];
   int n_errors = 0;
   int total_checks = 0;
   int nFan, nTemp, nForce;
   always #2 clk = ~clk;
   lcd_cmd_handler #(.EIGHTH_CYCLES(16)) dut_u (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .idWrEn(idWrEn), .idWrIdx(idWrIdx),
      .idWrData(idWrData), .cursorCol(cursorCol), .cursorRow(cursorRow),
      .cursorStyle(cursorStyle), .contrast(contrast), .backlight(backlight),
      .fanDrive(fanDrive), .rptValid(rptValid), .rptType(rptType), .rptIndex(rptIndex));
   sensor_scan_model #(.FAMILY(FAM), .COUNT(4), .PIN_DRIVE_MODE_FIELD(3'h7),
      .PIN_USER_FLAG(1'b0)) scan_u (.clk(clk), .rst_b(rst_b),
      .idWrEn(idWrEn), .idWrIdx(idWrIdx), .idWrData(idWrData));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] ack(input logic [7:0] t, input logic [3:0] n);
      return {15'h0, 1'b1, 4'h0, n, t | lcd_cmd_pkg::ACK_FLAG};
   endfunction
   function automatic logic [31:0] nak(input logic [7:0] t);
      return {15'h0, 1'b1, 8'h00, t | lcd_cmd_pkg::NAK_FLAG};
   endfunction
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         n_errors++;
         give_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic send(input logic [7:0] t);
      foreach (dq[i]) begin
         apb(1'b1, lcd_cmd_pkg::ADDR_DATA, {24'h0, dq[i]});
      end
      apb(1'b1, lcd_cmd_pkg::ADDR_CMD, {24'h0, t});
      apb(1'b0, lcd_cmd_pkg::ADDR_RSP, 32'h0);
      dq.delete();
   endtask
   task automatic chk_reply(input logic [7:0] t);
      `CHK(rd, ack(t, 4'h9))
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, lcd_cmd_pkg::ADDR_RBYTE + 8'(4 * i), 32'h0);
         `CHK(rd[7:0], eq[i])
      end
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      `CHK(contrast, lcd_cmd_pkg::CONTRAST_RST)
      `CHK(fanDrive, 28'h0)
      dq = '{8'h0f, 8'h01};
      send(lcd_cmd_pkg::CMD_CURPOS);
      `CHK(rd, ack(lcd_cmd_pkg::CMD_CURPOS, 4'h0))
      `CHK({cursorCol, cursorRow}, 5'h1f)
      dq = '{8'h10, 8'h00};
      send(lcd_cmd_pkg::CMD_CURPOS);
      `CHK(rd, nak(lcd_cmd_pkg::CMD_CURPOS))
      `CHK({cursorCol, cursorRow}, 5'h1f)
      dq = '{8'h03};
      send(lcd_cmd_pkg::CMD_CURSTYLE);
      `CHK(cursorStyle, 2'h3)
      dq = '{8'h04};
      send(lcd_cmd_pkg::CMD_CURSTYLE);
      `CHK(rd, nak(lcd_cmd_pkg::CMD_CURSTYLE))
      send(8'h0f);
      `CHK(rd, nak(8'h0f))
      r = lfsr(r);
      dq = '{r[7:0]};
      send(lcd_cmd_pkg::CMD_CONTRAST);
      `CHK(rd, 32'h1004d)
      `CHK(contrast, r[7:0])
      dq = '{r[15:8]};
      send(lcd_cmd_pkg::CMD_BACKLIGHT);
      `CHK(rd, 32'h1004e)
      `CHK(backlight, r[15:8])
      $display("test cursor and levels done");
      dq = '{8'h07};
      eq = '{8'h78, 8'h3f};
      for (int i = 0; i < 7; i++) begin
         r = lfsr(r);
         eq.push_back(r[7:0] & 8'h3f);
      end
      for (int i = 1; i < 9; i++) begin
         dq.push_back(eq[i]);
      end
      send(lcd_cmd_pkg::CMD_GLYPH);
      `CHK(rd, ack(lcd_cmd_pkg::CMD_GLYPH, 4'h0))
      dq = '{8'h78};
      send(lcd_cmd_pkg::CMD_PEEK);
      chk_reply(lcd_cmd_pkg::CMD_PEEK);
      dq = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      send(lcd_cmd_pkg::CMD_GLYPH);
      `CHK(rd, nak(lcd_cmd_pkg::CMD_GLYPH))
      $display("test glyph done");
      for (int i = 0; i < 16; i++) begin
         r = lfsr(r);
         dq.push_back(r[7:0]);
      end
      eq = '{8'h90};
      eq = {eq, dq[0:7], 8'h98, dq[8:15]};
      send(lcd_cmd_pkg::CMD_LINE2);
      `CHK(rd, ack(lcd_cmd_pkg::CMD_LINE2, 4'h0))
      for (int k = 0; k < 2; k++) begin
         dq = '{eq[0]};
         send(lcd_cmd_pkg::CMD_PEEK);
         chk_reply(lcd_cmd_pkg::CMD_PEEK);
         eq = eq[9:$];
      end
      $display("test line done");
      for (int i = 0; i < 4; i++) begin
         r = lfsr(r);
         fl[i] = 7'(r[7:0] % 8'd100);
         dq.push_back({1'b0, fl[i]});
      end
      send(lcd_cmd_pkg::CMD_FANPWR);
      `CHK(fanDrive, {fl[3], fl[2], fl[1], fl[0]})
      dq = '{8'h64, 8'h64, 8'h64, 8'h65};
      send(lcd_cmd_pkg::CMD_FANPWR);
      `CHK(fanDrive, {fl[3], fl[2], fl[1], fl[0]})
      dq = '{8'h03};
      eq = '{8'h03, FAM, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03, 8'h03};
      send(lcd_cmd_pkg::CMD_SENSINFO);
      chk_reply(lcd_cmd_pkg::CMD_SENSINFO);
      dq = '{8'h20};
      send(lcd_cmd_pkg::CMD_SENSINFO);
      `CHK(rd, nak(lcd_cmd_pkg::CMD_SENSINFO))
      apb(1'b0, 8'hfc, 32'h0);
      `CHK(err, 1'b1)
      $display("test fans and sensors done");
      dq = '{8'h04, 8'h00, 8'h00, 8'h80};
      send(lcd_cmd_pkg::CMD_TEMPRPT);
      apb(1'b0, lcd_cmd_pkg::ADDR_TMASK, 32'h0);
      `CHK(rd, 32'h8000_0004)
      // Reporting mask cut back to scanned thermometer indices
      dq = '{8'h04, 8'h00, 8'h00, 8'h00};
      send(lcd_cmd_pkg::CMD_TEMPRPT);
      `CHK(rd, ack(lcd_cmd_pkg::CMD_TEMPRPT, 4'h0))
      dq = '{8'h01};
      send(lcd_cmd_pkg::CMD_FANRPT);
      `CHK(rd, 32'h10050)
      apb(1'b0, lcd_cmd_pkg::ADDR_STAT, 32'h0);
      `CHK(rd, 32'h0000_0100)
      nFan = 0;
      nTemp = 0;
      nForce = 0;
      repeat (512) begin
         @(posedge clk);
         if (rptValid === 1'b1 && rptType === lcd_cmd_pkg::RPT_FAN) begin
            nFan += (rptIndex === 5'h00) ? 1 : 100;
         end
         if (rptValid === 1'b1 && rptType === lcd_cmd_pkg::RPT_TEMP) begin
            nTemp += (rptIndex === 5'h02) ? 1 : 100;
         end
         nForce += (fanDrive[0] === lcd_cmd_pkg::FAN_FULL) ? 1 : 0;
      end
      `CHK(nFan, 8)
      `CHK(nTemp, 4)
      `CHK(nForce, 128)
      $display("test reports done");
      // Restart with the sensor pin setting kept: bus scanned again
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (16) @(posedge clk);
      `CHK(fanDrive, 28'h0)
      dq = '{8'h03};
      send(lcd_cmd_pkg::CMD_SENSINFO);
      chk_reply(lcd_cmd_pkg::CMD_SENSINFO);
      $display("test restart done");
      give_verdict();
   end
endmodule
`default_nettype wire
